// >>> sssr_pkg.sv
/*
  Package for the status summary and service request block: field positions,
  command codes and the packed carriers shared by the design.
  Assumes a single 250 MHz clock domain and a command decoder upstream that
  presents one decoded command per cycle.
*/
package sssr_pkg;

  // Event register bit positions.
  localparam int unsigned EV_OPC_BIT   = 0;
  localparam int unsigned EV_QUERY_BIT = 2;
  localparam int unsigned EV_DEV_BIT   = 3;
  localparam int unsigned EV_EXE_BIT   = 4;
  localparam int unsigned EV_CMD_BIT   = 5;
  localparam int unsigned EV_PON_BIT   = 7;
  localparam logic [7:0]  EV_USED_MASK = 8'hBD;

  // Summary byte bit positions.
  localparam int unsigned SUM_MAV_BIT  = 4;
  localparam int unsigned SUM_ESB_BIT  = 5;
  localparam int unsigned SUM_RQS_BIT  = 6;
  localparam logic [7:0]  SUM_SRE_MASK = 8'hBF;

  localparam logic [7:0]  BYTE_ZERO    = 8'h00;
  localparam logic [7:0]  ENA_RESET    = 8'h00;

  // Decoded commands handed over by the command parser, in command order.
  typedef enum logic [3:0] {
    SSSR_CMD_NONE     = 4'b0000,
    SSSR_CMD_CLS      = 4'b0001,
    SSSR_CMD_ESE_WR   = 4'b0010,
    SSSR_CMD_ESE_RD   = 4'b0011,
    SSSR_CMD_ESR_RD   = 4'b0100,
    SSSR_CMD_SRE_WR   = 4'b0101,
    SSSR_CMD_SRE_RD   = 4'b0110,
    SSSR_CMD_STB_RD   = 4'b0111,
    SSSR_CMD_OPC      = 4'b1000,
    SSSR_CMD_PSC_WR   = 4'b1001,
    SSSR_CMD_PSC_RD   = 4'b1010,
    SSSR_CMD_LOCAL    = 4'b1011,
    SSSR_CMD_REMOTE   = 4'b1100,
    SSSR_CMD_LOCKOUT  = 4'b1101
  } sssr_cmd_e;

  typedef enum logic [1:0] {
    SSSR_PANEL_LOCAL   = 2'b00,
    SSSR_PANEL_REMOTE  = 2'b01,
    SSSR_PANEL_LOCKED  = 2'b10
  } sssr_panel_e;

  // One command with its operand.
  typedef struct packed {
    logic      valid;
    sssr_cmd_e cmd;
    logic [7:0] data;
  } sssr_cmd_s;

  // Event sources, one-cycle pulses from the rest of the instrument.
  typedef struct packed {
    logic query_err;
    logic device_err;
    logic exec_err;
    logic cmd_err;
  } sssr_events_s;

  // Query answer placed in the output path.
  typedef struct packed {
    logic       valid;
    logic [7:0] value;
  } sssr_resp_s;

endpackage

// >>> sssr_status.sv
/*
  Status summary and service request logic: latched event register, event and
  service-request enable masks, summary byte, serial poll, panel lockout modes
  and the serial abort character.
  Assumes an upstream parser that decodes commands in order and holds back a
  command while cmd_busy_o is high, and an output buffer that reports whether
  response data is waiting.
*/
// Functional notes
// - Event bits latch on their condition and hold until an explicit clear.
// - Reading the event register or clear-status clears all event bits.
// - Reset command and device clear leave event bits untouched.
// - Queries return register contents as a binary-weighted value.
// - The event summary bit is the OR of enabled event bits.
// - Enable registers read and write; reads and clear-status leave them.
// - Message-available, bit 4, follows waiting response data at once.
// - Summary bits 4 and 5 are not latched and follow their sources; request bit 6 is latched.
// - Message-available clears only when every buffered message is read; here it also reads 0 while output_flush_o is high.
// - Summary byte: bit 4 MESSAGE_AVAILABLE_BIT, bit 5 event summary, bit 6 request, others zero.
// - Clear-status and event read clear bits 5 and 6 of the summary byte; bit 4 is kept.
// - Summary mask clears on zero write, and at power-on when setting is one.
// - Request service rising from an enabled summary bit raises service request.
// - Request service clears only by serial poll, clear-status or reading the causing event register; here power-on and any event read clear it too.
// - Serial poll returns summary byte, clears only request service, never stalls.
// - Status-byte query runs in order and clears nothing.
// - Operation-complete sets event bit 0 once earlier commands finish.
// - Remote disables all keys but local; local re-enables all keys.
// - Remote-with-lockout enters remote and disables every key.
// - Serial abort ends the operation and discards output, like device clear.
// - Event bits: 0 OPC, 2 query, 3 device, 4 exec, 5 command, 7 power on.
// - Event enable mask loads from a written value and gates the event summary.
`timescale 1ns/10ps
module sssr_status
  import sssr_pkg::*;
(
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         power_on_i,
  input  wire sssr_cmd_s    cmd_i,
  input  wire sssr_events_s events_i,
  input  wire logic         exec_idle_i,
  input  wire logic         out_data_waiting_i,
  input  wire logic         serial_poll_i,
  input  wire logic         device_clear_i,
  input  wire logic         abort_char_i,
  output logic              cmd_busy_o,
  output sssr_resp_s        resp_o,
  output logic [7:0]        poll_byte_o,
  output logic              srq_o,
  output logic              output_flush_o,
  output logic              op_abort_o,
  output logic              remote_o,
  output logic [1:0]        panel_mode_o,
  output logic              keys_enabled_o,
  output logic              local_key_enabled_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Command acceptance.

  logic        [7:0] event_r;
  logic        [7:0] ese_r;
  logic        [7:0] sre_r;
  logic              psc_r;
  logic              rqs_r;
  logic              rqs_clr_pend_r;
  logic              opc_pend_r;
  sssr_panel_e       panel_r;
  logic        [7:0] summary;
  logic              esb;
  logic              clr_ev;
  logic              esr_rd;
  logic              clear_evt;
  logic              cmd_take;
  logic              ordered;

  // Commands that report results in command order wait for the execution
  // engine; the serial poll never goes through here, so it is never stalled.
  function automatic logic is_ordered(input sssr_cmd_e c);
    is_ordered = (c == SSSR_CMD_STB_RD) || (c == SSSR_CMD_OPC);
  endfunction

  assign ordered    = cmd_i.valid && is_ordered(cmd_i.cmd);
  assign cmd_busy_o = ordered && !exec_idle_i;
  assign cmd_take   = cmd_i.valid && !cmd_busy_o;
  assign clr_ev     = cmd_take && (cmd_i.cmd == SSSR_CMD_CLS);
  assign esr_rd     = cmd_take && (cmd_i.cmd == SSSR_CMD_ESR_RD);
  assign clear_evt  = clr_ev || esr_rd;

  ////////////////////////////////////////////////////////////////////////////
  // Event register.

  logic [7:0] ev_set;

  always_comb begin
    ev_set               = BYTE_ZERO;
    ev_set[EV_QUERY_BIT] = events_i.query_err;
    ev_set[EV_DEV_BIT]   = events_i.device_err;
    ev_set[EV_EXE_BIT]   = events_i.exec_err;
    ev_set[EV_CMD_BIT]   = events_i.cmd_err;
    ev_set[EV_OPC_BIT]   = opc_pend_r && exec_idle_i;
  end

  // A new event in the cycle of a clear survives the clear. Device clear and
  // abort do not reach this register at all.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      event_r <= BYTE_ZERO;
    end else if (power_on_i) begin
      event_r <= BYTE_ZERO;
      event_r[EV_PON_BIT] <= 1'b1;
    end else begin
      event_r <= ((clear_evt ? BYTE_ZERO : event_r) | ev_set) & EV_USED_MASK;
    end
  end

  // Operation complete is armed by the command and fires once the engine is idle.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || power_on_i) begin
      opc_pend_r <= 1'b0;
    end else if (cmd_take && cmd_i.cmd == SSSR_CMD_OPC) begin
      opc_pend_r <= 1'b1;
    end else if (exec_idle_i) begin
      opc_pend_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Enable masks and power-on clear setting.

  // The power-on clear setting would normally live in non-volatile storage;
  // here it survives power_on_i and resets only with rst_n_i.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      psc_r <= 1'b1;
    end else if (cmd_take && cmd_i.cmd == SSSR_CMD_PSC_WR) begin
      psc_r <= cmd_i.data[0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ese_r <= ENA_RESET;
    end else if (power_on_i) begin
      if (psc_r) begin
        ese_r <= ENA_RESET;
      end
    end else if (cmd_take && cmd_i.cmd == SSSR_CMD_ESE_WR) begin
      ese_r <= cmd_i.data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sre_r <= ENA_RESET;
    end else if (power_on_i) begin
      if (psc_r) begin
        sre_r <= ENA_RESET;
      end
    end else if (cmd_take && cmd_i.cmd == SSSR_CMD_SRE_WR) begin
      sre_r <= cmd_i.data & SUM_SRE_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Summary byte and service request.

  logic rqs_src;

  assign esb = |(event_r & ese_r);

  // Message available and the event summary follow their sources directly.
  always_comb begin
    summary              = BYTE_ZERO;
    summary[SUM_MAV_BIT] = out_data_waiting_i && !output_flush_o;
    summary[SUM_ESB_BIT] = esb;
    summary[SUM_RQS_BIT] = rqs_r;
  end

  assign rqs_src = |(summary & sre_r);

  // Request service latches on an enabled summary bit and drops on a poll or
  // on the event read; clear-status clears it too, along with the event bits.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || power_on_i) begin
      rqs_r <= 1'b0;
    end else if (serial_poll_i || esr_rd || clr_ev) begin
      rqs_r <= 1'b0;
    end else if (rqs_src && !rqs_clr_pend_r) begin
      rqs_r <= 1'b1;
    end
  end

  // After a clear, wait one cycle so that the cleared sources are seen.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rqs_clr_pend_r <= 1'b0;
    end else begin
      rqs_clr_pend_r <= serial_poll_i || esr_rd || clr_ev;
    end
  end

  assign srq_o       = rqs_r;
  assign poll_byte_o = summary;

  ////////////////////////////////////////////////////////////////////////////
  // Query answers.

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      resp_o <= '0;
    end else begin
      resp_o.valid <= 1'b0;
      if (cmd_take) begin
        case (cmd_i.cmd)
          SSSR_CMD_ESR_RD: begin
            resp_o <= '{valid: 1'b1, value: event_r};
          end
          SSSR_CMD_ESE_RD: begin
            resp_o <= '{valid: 1'b1, value: ese_r};
          end
          SSSR_CMD_SRE_RD: begin
            resp_o <= '{valid: 1'b1, value: sre_r};
          end
          SSSR_CMD_STB_RD: begin
            resp_o <= '{valid: 1'b1, value: summary};
          end
          SSSR_CMD_PSC_RD: begin
            resp_o <= '{valid: 1'b1, value: {7'h00, psc_r}};
          end
          default: begin
            resp_o.valid <= 1'b0;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output flush and abort.

  // Device clear, the serial abort character and power-on all discard output.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      output_flush_o <= 1'b1;
      op_abort_o     <= 1'b0;
    end else begin
      output_flush_o <= device_clear_i || abort_char_i || power_on_i;
      op_abort_o     <= device_clear_i || abort_char_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Front-panel remote and lockout modes.

  always_ff @(posedge clk_i) begin
    if (!rst_n_i || power_on_i) begin
      panel_r <= SSSR_PANEL_LOCAL;
    end else if (cmd_take) begin
      case (cmd_i.cmd)
        SSSR_CMD_LOCAL:   panel_r <= SSSR_PANEL_LOCAL;
        SSSR_CMD_REMOTE:  panel_r <= SSSR_PANEL_REMOTE;
        SSSR_CMD_LOCKOUT: panel_r <= SSSR_PANEL_LOCKED;
        default:          panel_r <= panel_r;
      endcase
    end
  end

  assign panel_mode_o        = panel_r;
  assign remote_o            = (panel_r != SSSR_PANEL_LOCAL);
  assign keys_enabled_o      = (panel_r == SSSR_PANEL_LOCAL);
  assign local_key_enabled_o = (panel_r != SSSR_PANEL_LOCKED);

endmodule

// >>> sssr_status_chk.sv
/* Port checker for the status summary block.
   Assumes one clock domain and a bind from the bench. */
`timescale 1ns/10ps
module sssr_status_chk
  import sssr_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire sssr_cmd_s  cmd_i,
  input wire logic       exec_idle_i,
  input wire logic       out_data_waiting_i,
  input wire logic       serial_poll_i,
  input wire logic       abort_char_i,
  input wire logic       cmd_busy_o,
  input wire sssr_resp_s resp_o,
  input wire logic [7:0] poll_byte_o,
  input wire logic       srq_o,
  input wire logic       output_flush_o,
  input wire logic       op_abort_o,
  input wire logic       remote_o,
  input wire logic       keys_enabled_o,
  input wire logic       local_key_enabled_o
);
  logic tk;
  assign tk = cmd_i.valid && !cmd_busy_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////////////////////
  chk_zero_bits: assert property ((poll_byte_o & 8'h8F) == 8'h00)
    else $error("Unused summary bits set");
  chk_mav_live: assert property (poll_byte_o[4] == out_data_waiting_i)
    else $error("MESSAGE_AVAILABLE_BIT wrong");
  chk_rqs_srq: assert property ((poll_byte_o[6] == srq_o) and
    ($rose(srq_o) |-> $past(poll_byte_o[5:4]) != 2'h0))
    else $error("RQS and SRQ differ");
  chk_poll_clears: assert property (serial_poll_i |=> !srq_o)
    else $error("Poll left SRQ");
  chk_esr_clears: assert property (tk && cmd_i.cmd == SSSR_CMD_ESR_RD |=> !srq_o && resp_o.valid)
    else $error("Event read wrong");
  chk_busy_hold: assert property (cmd_i.valid && !exec_idle_i &&
    (cmd_i.cmd == SSSR_CMD_STB_RD || cmd_i.cmd == SSSR_CMD_OPC) |-> cmd_busy_o) else $error("No hold off");
  chk_lockout_keys: assert property (tk && cmd_i.cmd == SSSR_CMD_LOCKOUT
    |=> remote_o && !keys_enabled_o && !local_key_enabled_o) else $error("Lockout wrong");
  chk_remote_keys: assert property (tk && cmd_i.cmd == SSSR_CMD_REMOTE
    |=> remote_o && !keys_enabled_o && local_key_enabled_o) else $error("Remote wrong");
  chk_abort_flush: assert property ($rose(abort_char_i) |=> output_flush_o && op_abort_o)
    else $error("Abort no flush");
endmodule

// >>> sssr_ctl_model.sv
/* Bus controller model that answers a service request with a serial poll.
   Assumes the block's clock and summary byte. */
`timescale 1ns/10ps
module sssr_ctl_model (
  input  wire logic       clk_i,
  input  wire logic       poll_en_i,
  input  wire logic       srq_i,
  input  wire logic [7:0] poll_byte_i,
  output logic            serial_poll_o,
  output logic [7:0]      polled_o,
  output logic [7:0]      poll_cnt_o
);
  int wait_q = 0;
  initial begin
    serial_poll_o = 1'b0;
    polled_o = 8'h00;
    poll_cnt_o = 8'h00;
  end
  // A real controller notices the request late, so two cycles pass first.
  always @(posedge clk_i) begin
    #1;
    serial_poll_o = poll_en_i && srq_i === 1'b1 && wait_q == 2;
    if (serial_poll_o) begin
      polled_o = poll_byte_i;
      poll_cnt_o = poll_cnt_o + 8'h01;
      wait_q = 0;
    end else if (poll_en_i && srq_i === 1'b1) begin
      wait_q++;
    end
  end
endmodule

// >>> status_summary_and_service_request_bench.sv
/* Self-checking bench for the status summary block.
   Assumes the block, checker and controller model are compiled first. */
`timescale 1ns/10ps
module status_summary_and_service_request_bench
  import sssr_pkg::*;
;
  logic         clk_i = 1'b0, rst_n_i = 1'b0, power_on_i = 1'b0, exec_idle_i = 1'b1;
  logic         out_data_waiting_i = 1'b0, device_clear_i = 1'b0, abort_char_i = 1'b0;
  logic         serial_poll_i, poll_en = 1'b0, cmd_busy_o, srq_o, output_flush_o, op_abort_o;
  logic         remote_o, keys_enabled_o, local_key_enabled_o;
  sssr_cmd_s    cmd_i = '0;
  sssr_events_s events_i = '0;
  sssr_resp_s   resp_o;
  logic [7:0]   poll_byte_o, polled, poll_cnt, ese, sre, ev;
  logic [1:0]   panel_mode_o;
  logic [3:0]   e;
  int           err_count = 0, num_checks = 0, seed = 18, p;
  sssr_cmd_e    pc [3] = '{SSSR_CMD_LOCAL, SSSR_CMD_LOCKOUT, SSSR_CMD_REMOTE};
  logic [1:0]   pm [3] = '{2'h0, 2'h2, 2'h1};
  always #2 clk_i = ~clk_i;
  sssr_status DUT (.*);
  sssr_ctl_model u_ctl (.clk_i(clk_i), .poll_en_i(poll_en), .srq_i(srq_o), .poll_byte_i(poll_byte_o),
    .serial_poll_o(serial_poll_i), .polled_o(polled), .poll_cnt_o(poll_cnt));
  ////////////////////////////////////////////////////////////////////////////
  task automatic tick;
    @(posedge clk_i) #1;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Commands are spaced by an idle cycle so valid is never set twice at once.
  // Busy is looked at on the edge itself, so the command drops right after the
  // edge that takes it and is never taken twice when busy falls mid-cycle.
  task automatic op(input sssr_cmd_e c, input logic [7:0] d, input bit rd, input logic [7:0] x);
    int n;
    tick;
    cmd_i = '{1'b1, c, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (cmd_busy_o !== 1'b0 && n < 50);
    chk({7'h00, cmd_busy_o}, 8'h00);
    #1;
    cmd_i.valid = 1'b0;
    if (rd) begin
      chk({7'h00, resp_o.valid}, 8'h01);
      chk(resp_o.value, x);
    end
  endtask
  task automatic final_report;
    $display("Checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    op(SSSR_CMD_ESR_RD, 8'h00, 1, 8'h00);
    op(SSSR_CMD_PSC_RD, 8'h00, 1, 8'h01);
    for (int i = 0; i < 3; i++) begin
      op(pc[i], 8'h00, 0, 8'h00);
      chk({6'h00, panel_mode_o}, {6'h00, pm[i]});
    end
    $display("Test reset and panel done");
    for (p = 1; p >= 0; p--) begin
      ese = 8'($random(seed)) & 8'hBD;
      sre = 8'($random(seed)) & 8'hBF;
      op(SSSR_CMD_PSC_WR, p[7:0], 0, 8'h00);
      op(SSSR_CMD_ESE_WR, ese, 0, 8'h00);
      op(SSSR_CMD_SRE_WR, sre, 0, 8'h00);
      tick;
      power_on_i = 1'b1;
      tick;
      power_on_i = 1'b0;
      op(SSSR_CMD_REMOTE, 8'h00, 0, 8'h00);
      if (p == 1) {ese, sre} = 16'h0000;
      op(SSSR_CMD_ESE_RD, 8'h00, 1, ese);
      op(SSSR_CMD_SRE_RD, 8'h00, 1, sre);
      op(SSSR_CMD_ESR_RD, 8'h00, 1, 8'h80);
    end
    $display("Test power on done");
    repeat (4) begin
      e = 4'($random(seed));
      ev = {2'b00, e[0], e[1], e[2], e[3], 2'b00};
      tick;
      events_i = e;
      tick;
      events_i = '0;
      {device_clear_i, abort_char_i} = 2'b11;
      tick;
      {device_clear_i, abort_char_i} = 2'b00;
      op(SSSR_CMD_ESR_RD, 8'h00, 1, ev);
      op(SSSR_CMD_ESR_RD, 8'h00, 1, 8'h00);
    end
    $display("Test events done");
    out_data_waiting_i = 1'($random(seed));
    op(SSSR_CMD_CLS, 8'h00, 0, 8'h00);
    op(SSSR_CMD_ESE_WR, 8'h3C, 0, 8'h00);
    op(SSSR_CMD_SRE_WR, 8'h20, 0, 8'h00);
    tick;
    events_i = 4'b0010;
    tick;
    events_i = '0;
    poll_en = 1'b1;
    repeat (12) tick;
    poll_en = 1'b0;
    chk({7'h00, poll_cnt != 8'h00}, 8'h01);
    chk(polled, {3'b011, out_data_waiting_i, 4'h0});
    repeat (3) tick;
    op(SSSR_CMD_STB_RD, 8'h00, 1, {3'b011, out_data_waiting_i, 4'h0});
    op(SSSR_CMD_ESR_RD, 8'h00, 1, 8'h10);
    op(SSSR_CMD_CLS, 8'h00, 0, 8'h00);
    repeat (3) tick;
    chk({7'h00, srq_o}, 8'h00);
    op(SSSR_CMD_ESE_RD, 8'h00, 1, 8'h3C);
    $display("Test service request done");
    exec_idle_i = 1'b0;
    fork
      op(SSSR_CMD_OPC, 8'h00, 0, 8'h00);
      begin
        repeat (5) tick;
        exec_idle_i = 1'b1;
      end
    join
    op(SSSR_CMD_ESR_RD, 8'h00, 1, 8'h01);
    $display("Test operation complete done");
    final_report();
  end
  initial begin
    #100000;
    err_count++;
    final_report();
  end
endmodule
bind sssr_status sssr_status_chk u_chk (.*);
